/* File: bsps_host_model.sv */
// Host model: raises the hold request some cycles after adapter-good.
// Assumes the adapter-good enable of the sequencer and a shared clock.
`timescale 1ns/1ps
module bsps_host_model (
    input  wire logic clk,
    input  wire logic en,
    input  wire logic ag_oe,
    output logic      hold
);
    logic [3:0] cnt_r;
    initial begin
        cnt_r = 4'h0;
        hold  = 1'b0;
    end
    // Slow on purpose, but well inside the one-shot; stays high until disabled
    always @(posedge clk) begin
        cnt_r <= (en && ag_oe) ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
        hold  <= #1 en && (hold || cnt_r == 4'hf);
    end
endmodule

/* File: bsps_map.svh */
// Constants of the battery switch power sequencer: timing figures and counts.
// Assumes a 10 MHz clock; counts are derived from the printed times.
`ifndef BSPS_MAP_SVH
`define BSPS_MAP_SVH
`define BSPS_CLK_HZ        10000000
`define BSPS_DEBOUNCE_US   25000
`define BSPS_ONESHOT_US    1200000
`define BSPS_BLANK_US      10000
`define BSPS_DEBOUNCE_CYC  ((`BSPS_DEBOUNCE_US * (`BSPS_CLK_HZ / 1000000)))
`define BSPS_ONESHOT_CYC   ((`BSPS_ONESHOT_US * (`BSPS_CLK_HZ / 1000000)))
`define BSPS_BLANK_CYC     ((`BSPS_BLANK_US * (`BSPS_CLK_HZ / 1000000)))
`endif

/* File: bsps_pkg.sv */
// Types of the battery switch power sequencer.
// Assumes bsps_map.svh for the numeric constants.
package bsps_pkg;
    typedef enum logic [1:0] {
        BSPS_BAT_DEAD,
        BSPS_BAT_LOW,
        BSPS_BAT_OK
    } bsps_bat_e;

    typedef struct packed {
        logic in_undervoltage_lockout;
        logic in_overvoltage_lockout;
        logic bat_above_low;
        logic bat_above_high;
        logic cur_limit;
        logic over_temp;
    } bsps_flags_s;

    typedef struct packed {
        logic power_on_request;
        logic power_hold_request;
        logic carkit_detect;
        logic shutdown;
    } bsps_req_s;

    typedef enum logic [1:0] {
        BSPS_SW_OFF,
        BSPS_SW_ON,
        BSPS_SW_FAULT,
        BSPS_SW_REARM
    } bsps_sw_e;
endpackage

/* File: bsps_sequencer.sv */
// What this block does
// - Undervoltage keeps gate off, adapter-good released.
// - Overvoltage keeps gate off, adapter-good released.
// - Adapter-good asserts after 25ms in window.
// - Adapter-good releases one clock after fault.
// - Echo output inverts power-on request.
// - Echo released with no adapter, low battery.
// - Low battery ignores power-on, echo high.
// - Battery recovery restores power-on and echo.
// - Carkit, power-on or hold turn switch on.
// - Dead battery keeps switch off always.
// - Adapter-good assertion starts 1.2s one-shot.
// - Switch off when requests low, one-shots expired.
// - Carkit rising edge without adapter starts one-shot.
// - Limiting after 10ms turn-on blanking faults.
// - Limiting while on beyond blanking faults.
// - Fault clears after removal then re-cycle.
// - Low battery: power-on has no switch effect.
// - Low battery drops power-on-only hold, keeps hold.
// - Over-temperature faults; same clearing after drop.
// - Shutdown input turns gate drive and adapter-good off.
////////////////////////////////////////////////////////////////////////////////
// File holds the single sequencer module.
// Assumes comparator flags and host inputs synchronous to clk.
`timescale 1ns/1ps
`include "bsps_map.svh"

module bsps_sequencer
    import bsps_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `BSPS_DEBOUNCE_CYC,
    parameter int ONESHOT_CYC  = `BSPS_ONESHOT_CYC,
    parameter int BLANK_CYC    = `BSPS_BLANK_CYC
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire bsps_flags_s flags,
    input  wire bsps_req_s   req,
    output logic             nfet_gate_drive,
    output logic             adapter_good_n_o,
    output logic             adapter_good_n_oe,
    output logic             power_on_echo_n_o,
    output logic             power_on_echo_n_oe,
    output logic             battery_switch,
    output logic             fault
);
    localparam int CW = 24;

    // Counts must fit the shared counter width; refuse them at elaboration
    if (DEBOUNCE_CYC < 1 || ONESHOT_CYC < 1 || BLANK_CYC < 1 ||
        DEBOUNCE_CYC >= (1 << CW) || ONESHOT_CYC >= (1 << CW) ||
        BLANK_CYC >= (1 << CW)) begin : g_range_chk
        $error("bsps_sequencer: timing count out of range");
    end

    function automatic logic [CW-1:0] cnt_dec(input logic [CW-1:0] c);
        cnt_dec = (c != '0) ? c - 24'h000001 : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Adapter window and battery band
    logic      in_window;
    logic      adapter_present;
    bsps_bat_e bat;
    assign in_window       = !flags.in_undervoltage_lockout && !flags.in_overvoltage_lockout && !req.shutdown;
    assign adapter_present = !flags.in_undervoltage_lockout;
    assign bat = !flags.bat_above_low  ? BSPS_BAT_DEAD :
                 !flags.bat_above_high ? BSPS_BAT_LOW  : BSPS_BAT_OK;

    ////////////////////////////////////////////////////////////////////////////
    // Debounce and adapter-good
    logic [CW-1:0] deb_r, deb_nxt;
    logic          good_r, good_nxt;
    always_comb begin
        deb_nxt  = deb_r;
        good_nxt = good_r;
        if (!in_window) begin
            deb_nxt  = '0;
            good_nxt = 1'b0;
        end else if (!good_r) begin
            if (deb_r == CW'(DEBOUNCE_CYC - 1))
                good_nxt = 1'b1;
            else
                deb_nxt = deb_r + 24'h000001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            deb_r  <= '0;
            good_r <= 1'b0;
        end else begin
            deb_r  <= deb_nxt;
            good_r <= good_nxt;
        end
    end
    // Gate follows the window; analog charge pump is outside this block
    assign nfet_gate_drive   = in_window;
    assign adapter_good_n_o  = 1'b0;
    assign adapter_good_n_oe = good_r;

    ////////////////////////////////////////////////////////////////////////////
    // One-shots and echo memory
    logic [CW-1:0] os_ad_r, os_ad_nxt, os_ck_r, os_ck_nxt;
    logic          ck_prev_r, hold_prev_r, good_prev_r;
    logic          echo_mem_r, echo_mem_nxt;
    logic          ck_rise, hold_rise, good_rise;
    assign ck_rise   = req.carkit_detect && !ck_prev_r;
    assign hold_rise = req.power_hold_request && !hold_prev_r;
    assign good_rise = good_r && !good_prev_r;
    always_comb begin
        os_ad_nxt    = cnt_dec(os_ad_r);
        os_ck_nxt    = cnt_dec(os_ck_r);
        echo_mem_nxt = echo_mem_r;
        if (good_rise)
            os_ad_nxt = CW'(ONESHOT_CYC);
        if (ck_rise && !adapter_present)
            os_ck_nxt = CW'(ONESHOT_CYC);
        if (!req.carkit_detect)
            os_ck_nxt = '0;
        if (bat == BSPS_BAT_OK)
            echo_mem_nxt = req.power_on_request;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            os_ad_r     <= '0;
            os_ck_r     <= '0;
            ck_prev_r   <= 1'b0;
            hold_prev_r <= 1'b0;
            good_prev_r <= 1'b0;
            echo_mem_r  <= 1'b0;
        end else begin
            os_ad_r     <= os_ad_nxt;
            os_ck_r     <= os_ck_nxt;
            ck_prev_r   <= req.carkit_detect;
            hold_prev_r <= req.power_hold_request;
            good_prev_r <= good_r;
            echo_mem_r  <= echo_mem_nxt;
        end
    end

    // Echo is driven low while power-on is high in normal battery
    always_comb begin
        power_on_echo_n_o  = 1'b0;
        power_on_echo_n_oe = 1'b0;
        if (bat == BSPS_BAT_OK)
            power_on_echo_n_oe = echo_mem_r;
        else if (bat == BSPS_BAT_LOW && adapter_present)
            power_on_echo_n_oe = 1'b0;
        else
            power_on_echo_n_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Battery switch with current-limit and thermal latch-off
    logic     os_active, want_on, pon_ok;
    bsps_sw_e sw_r, sw_nxt;
    logic [CW-1:0] blk_r, blk_nxt;
    // Echo memory lags by a cycle; using live request keeps recovery prompt
    assign pon_ok    = (bat == BSPS_BAT_OK) && req.power_on_request;
    assign os_active = (os_ad_r != '0) || (os_ck_r != '0);
    assign want_on   = req.carkit_detect || pon_ok ||
                       req.power_hold_request || os_active;
    always_comb begin
        sw_nxt  = sw_r;
        blk_nxt = blk_r;
        unique case (sw_r)
            BSPS_SW_OFF: begin
                blk_nxt = '0;
                if (want_on && bat != BSPS_BAT_DEAD && !flags.over_temp)
                    sw_nxt = BSPS_SW_ON;
            end
            BSPS_SW_ON: begin
                // One counter serves both turn-on inrush and later shorts
                blk_nxt = flags.cur_limit ? blk_r + 24'h000001 : '0;
                if (flags.over_temp)
                    sw_nxt = BSPS_SW_FAULT;
                else if (flags.cur_limit && blk_r == CW'(BLANK_CYC - 1))
                    sw_nxt = BSPS_SW_FAULT;
                else if (bat == BSPS_BAT_DEAD || !want_on)
                    sw_nxt = BSPS_SW_OFF;
            end
            BSPS_SW_FAULT: begin
                blk_nxt = '0;
                if (!flags.over_temp && !os_active && !req.power_on_request &&
                    !req.power_hold_request)
                    sw_nxt = BSPS_SW_REARM;
            end
            BSPS_SW_REARM: begin
                blk_nxt = '0;
                if (flags.over_temp)
                    sw_nxt = BSPS_SW_FAULT;
                else if (good_rise || hold_rise)
                    sw_nxt = BSPS_SW_OFF;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_r  <= BSPS_SW_OFF;
            blk_r <= '0;
        end else begin
            sw_r  <= sw_nxt;
            blk_r <= blk_nxt;
        end
    end
    assign battery_switch = (sw_r == BSPS_SW_ON) && (bat != BSPS_BAT_DEAD);
    assign fault          = (sw_r == BSPS_SW_FAULT) || (sw_r == BSPS_SW_REARM);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ack_release_a: assert property (@(posedge clk) disable iff (srst)
        !in_window |=> !adapter_good_n_oe) else $error("adapter-good not released");
    gate_undervoltage_lockout_a: assert property (@(posedge clk) disable iff (srst)
        flags.in_undervoltage_lockout |-> !nfet_gate_drive) else $error("gate on in undervoltage_lockout");
    gate_overvoltage_lockout_a: assert property (@(posedge clk) disable iff (srst)
        flags.in_overvoltage_lockout |-> !nfet_gate_drive) else $error("gate on in overvoltage_lockout");
    ack_delay_a: assert property (@(posedge clk) disable iff (srst)
        $rose(adapter_good_n_oe) |-> $past(in_window, 2)) else $error("early adapter-good");
    dead_off_a: assert property (@(posedge clk) disable iff (srst)
        !flags.bat_above_low |-> !battery_switch) else $error("switch on dead battery");
    echo_low_a: assert property (@(posedge clk) disable iff (srst)
        !flags.bat_above_high |-> !power_on_echo_n_oe) else $error("echo driven low battery");
    echo_inv_a: assert property (@(posedge clk) disable iff (srst)
        flags.bat_above_high && $past(flags.bat_above_high) |->
        power_on_echo_n_oe == $past(req.power_on_request)) else $error("echo mismatch");
    os_start_a: assert property (@(posedge clk) disable iff (srst)
        good_rise |=> os_ad_r == CW'(ONESHOT_CYC)) else $error("one-shot not started");
    blank_trip_a: assert property (@(posedge clk) disable iff (srst)
        battery_switch && !flags.over_temp && flags.cur_limit && blk_r == CW'(BLANK_CYC - 1)
        |=> fault && !battery_switch) else $error("no trip after blanking");
    temp_trip_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_ON && flags.over_temp |=> fault) else $error("no thermal fault");

    ////////////////////////////////////////////////////////////////////////////
    // Cycle-exact checks against the registered state
    // Consequents name the state register where a dead battery could
    // mask the switch output combinationally in the same cycle

    ack_hold_a: assert property (@(posedge clk) disable iff (srst)
        in_window && !good_r && deb_r != CW'(DEBOUNCE_CYC - 1) |=> !adapter_good_n_oe)
        else $error("adapter-good before debounce end");

    deb_restart_a: assert property (@(posedge clk) disable iff (srst)
        !in_window |=> deb_r == '0)
        else $error("debounce not restarted");

    gate_sd_a: assert property (@(posedge clk) disable iff (srst)
        req.shutdown |-> !nfet_gate_drive)
        else $error("gate on in shutdown");

    echo_band_a: assert property (@(posedge clk) disable iff (srst)
        flags.bat_above_low && !flags.bat_above_high |-> !power_on_echo_n_oe)
        else $error("echo driven in low band");

    ck_start_a: assert property (@(posedge clk) disable iff (srst)
        ck_rise && !adapter_present |=> os_ck_r == CW'(ONESHOT_CYC))
        else $error("carkit one-shot not started");

    ck_cancel_a: assert property (@(posedge clk) disable iff (srst)
        !req.carkit_detect |=> os_ck_r == '0)
        else $error("carkit one-shot not cancelled");

    sw_on_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_OFF && want_on && bat != BSPS_BAT_DEAD && !flags.over_temp
        |=> sw_r == BSPS_SW_ON) else $error("switch not turned on");

    sw_off_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_ON && !want_on |=> !battery_switch)
        else $error("switch not turned off");

    os_run_a: assert property (@(posedge clk) disable iff (srst)
        os_active && flags.bat_above_low && sw_r == BSPS_SW_ON && !flags.cur_limit &&
        !flags.over_temp |=> sw_r == BSPS_SW_ON) else $error("one-shot hold lost");

    pon_ignore_a: assert property (@(posedge clk) disable iff (srst)
        flags.bat_above_low && !flags.bat_above_high && !req.power_hold_request &&
        !req.carkit_detect && !os_active |=> !battery_switch) else $error("power-on acted");

    hold_keep_a: assert property (@(posedge clk) disable iff (srst)
        flags.bat_above_low && !flags.bat_above_high && sw_r == BSPS_SW_ON &&
        req.power_hold_request && !flags.cur_limit && !flags.over_temp
        |=> sw_r == BSPS_SW_ON) else $error("hold lost in low band");

    fault_stay_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_FAULT && (flags.over_temp || os_active || req.power_on_request ||
        req.power_hold_request) |=> fault) else $error("fault cleared early");

    fault_off_a: assert property (@(posedge clk) disable iff (srst)
        fault |=> !battery_switch)
        else $error("switch on straight from fault");

    echo_keep_a: assert property (@(posedge clk) disable iff (srst)
        flags.bat_above_low && !flags.bat_above_high |=> $stable(echo_mem_r))
        else $error("echo memory lost");

    blank_tol_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_ON && flags.cur_limit && blk_r != CW'(BLANK_CYC - 1) &&
        !flags.over_temp && want_on && flags.bat_above_low
        |=> sw_r == BSPS_SW_ON) else $error("trip inside blanking");

    temp_off_a: assert property (@(posedge clk) disable iff (srst)
        flags.over_temp |=> !battery_switch)
        else $error("switch on while hot");

    temp_keep_a: assert property (@(posedge clk) disable iff (srst)
        sw_r == BSPS_SW_FAULT && flags.over_temp |=> sw_r == BSPS_SW_FAULT)
        else $error("thermal fault left while hot");
endmodule

/* File: bsps_sequencer_tb.sv */
// Self-checking bench of the sequencer with shortened timers.
// Assumes the host model beside it; inputs change 1 ns after clk rises, plus 6 ns for each check made before they are set.
`timescale 1ns/1ps
module bsps_sequencer_tb;
    import bsps_pkg::*;
    localparam int DB = 20;
    localparam int OS = 100;
    localparam int BK = 10;
    logic        clk, srst, pon, hold, ck, sd, h_en, h_hold, sw, flt, gate, ag, ec;
    bsps_flags_s f;
    bsps_req_s   req;
    int          num_errors, comparisons, seed;
    logic [4:0]  q_m[$], q_v[$];
    event        ev;
    assign req = {pon, hold | h_hold, ck, sd};
    bsps_sequencer #(.DEBOUNCE_CYC(DB), .ONESHOT_CYC(OS), .BLANK_CYC(BK)) u_dut (
        .clk(clk), .srst(srst), .flags(f), .req(req), .nfet_gate_drive(gate),
        .adapter_good_n_o(), .adapter_good_n_oe(ag), .power_on_echo_n_o(),
        .power_on_echo_n_oe(ec), .battery_switch(sw), .fault(flt));
    bsps_host_model u_host (.clk(clk), .en(h_en), .ag_oe(ag), .hold(h_hold));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("compared %0d, bad %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(logic [4:0] s, logic [4:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t saw %b want %b", $time, s, e);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bits: switch, fault, adapter-good, echo, gate; note mask and value
    task automatic chk(logic [4:0] m, logic [4:0] v);
        #5;
        q_m.push_back(m);
        q_v.push_back(v);
        ->ev;
        #1;
    endtask
    initial forever begin
        @(ev);
        cmp({sw, flt, ag, ec, gate} & q_m.pop_front(), q_v.pop_front());
    end
    initial begin
        #(100 * 3000);
        num_errors++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 14395;
        {srst, pon, hold, ck, sd, h_en} = 6'h20;
        f = 6'b101100;
        tick(10);
        srst = 1'b0;
        chk(5'h1f, 5'h00);
        f.in_undervoltage_lockout = 1'b0;
        tick(DB - 5);
        chk(5'h05, 5'h01);
        f.in_undervoltage_lockout = 1'b1;
        tick(1);
        f.in_undervoltage_lockout = 1'b0;
        tick(DB - 1);
        chk(5'h04, 5'h00);
        tick(1);
        chk(5'h04, 5'h04);
        tick(3);
        chk(5'h10, 5'h10);
        tick(OS + 1);
        chk(5'h10, 5'h00);
        f.in_overvoltage_lockout = 1'b1;
        chk(5'h01, 5'h00);
        tick(1);
        chk(5'h04, 5'h00);
        h_en = 1'b1;
        f.in_overvoltage_lockout = 1'b0;
        tick(DB + OS + 20);
        chk(5'h14, 5'h14);
        h_en = 1'b0;
        f.in_undervoltage_lockout = 1'b1;
        tick(3);
        chk(5'h14, 5'h00);
        $display("adapter tests done");
        // Random power-on levels: echo and switch both follow it
        repeat (8) begin
            pon = 1'($random(seed));
            tick(2);
            chk(5'h12, {pon, 2'b00, pon, 1'b0});
        end
        pon = 1'b1;
        hold = 1'b1;
        tick(2);
        f.bat_above_high = 1'b0;
        tick(2);
        chk(5'h12, 5'h10);
        hold = 1'b0;
        tick(2);
        chk(5'h12, 5'h00);
        f.bat_above_high = 1'b1;
        tick(2);
        chk(5'h12, 5'h12);
        {pon, hold} = 2'b01;
        f.bat_above_low = 1'b0;
        f.bat_above_high = 1'b0;
        chk(5'h10, 5'h00);
        tick(2);
        f.bat_above_low = 1'b1;
        tick(2);
        f.bat_above_high = 1'b1;
        hold = 1'b0;
        tick(3);
        $display("battery tests done");
        // Turn-on into a short: blanking runs out, then the fault latches
        hold = 1'b1;
        f.cur_limit = 1'b1;
        tick(BK + 3);
        chk(5'h18, 5'h08);
        hold = 1'b0;
        f.cur_limit = 1'b0;
        tick(3);
        chk(5'h18, 5'h08);
        hold = 1'b1;
        tick(3);
        chk(5'h18, 5'h10);
        f.cur_limit = 1'b1;
        tick(BK - 2);
        f.cur_limit = 1'b0;
        tick(1);
        chk(5'h18, 5'h10);
        f.cur_limit = 1'b1;
        tick(BK + 1);
        chk(5'h18, 5'h08);
        {hold, f.cur_limit} = 2'b00;
        tick(3);
        hold = 1'b1;
        tick(3);
        f.over_temp = 1'b1;
        tick(2);
        chk(5'h18, 5'h08);
        f.over_temp = 1'b0;
        hold = 1'b0;
        tick(3);
        hold = 1'b1;
        tick(3);
        chk(5'h18, 5'h10);
        hold = 1'b0;
        tick(3);
        $display("fault tests done");
        ck = 1'b1;
        tick(3);
        chk(5'h10, 5'h10);
        ck = 1'b0;
        tick(3);
        chk(5'h10, 5'h00);
        f.in_undervoltage_lockout = 1'b0;
        sd = 1'b1;
        chk(5'h01, 5'h00);
        sd = 1'b0;
        chk(5'h01, 5'h01);
        $display("carkit and shutdown tests done");
        end_sim();
    end
endmodule
